//--- common/flow_ctrl_regs.svh
// Register offsets, field positions and reset values of the flow controller.
// Included by its bare name; definitions only.
`ifndef FLOW_CTRL_REGS_SVH
`define FLOW_CTRL_REGS_SVH

// Byte offsets of the AXI4-Lite register words
`define REG_SELECT 8'h00
`define REG_MODE 8'h04
`define REG_COMMAND 8'h08
`define REG_BLOCKS 8'h0C
`define REG_STATUS 8'h10
`define REG_ORIGIN_TAG 8'h14
`define REG_SPAN_HI 7

// Select register fields
`define SEL_STREAM_LSB 0
`define SEL_ORIGIN_LSB 8
`define SEL_ALL_VALUE 8'hFF

// Mode register fields
`define MODE_METHOD_LSB 0
`define MODE_STYLE_BIT 4

// Command bits
`define CMD_BEGIN_BIT 0
`define CMD_HALT_BIT 1
`define CMD_FLUSH_BIT 2
`define CMD_SUSPEND_BIT 3
`define CMD_CONTINUE_BIT 4

// Reset values
`define RST_SELECT 32'h0000_0000
`define RST_MODE 32'h0000_0000
`define RST_BLOCKS 32'h0000_0001

// Base of origin tags; arbitrary value
`define ORIGIN_TAG_BASE 32'h0000_0A00

`endif

//--- common/flow_ctrl_pkg.sv
// Types shared by the flow controller files.
// No assumptions beyond a SystemVerilog compiler.
`default_nettype none
package flow_ctrl_pkg;

	// Flow control method
	typedef enum logic [1:0] {
		METHOD_BASIC = 2'h0,
		METHOD_AUTO = 2'h1,
		METHOD_MANUAL = 2'h2
	} flow_method_t;

	// Streaming state, one-hot
	typedef enum logic [3:0] {
		ST_STOPPED = 4'h1,
		ST_STOPPING = 4'h2,
		ST_STREAMING = 4'h4,
		ST_PAUSED = 4'h8
	} stream_state_t;

endpackage
`default_nettype wire

//--- hw/block_queue.sv
// Word queue that holds block data until it has been sent.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module block_queue #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Control
	input wire logic flush,
	// Write side
	input wire logic wrValid,
	input wire logic [WIDTH-1:0] wrData,
	output logic wrReady,
	// Read side
	output logic rdValid,
	output logic [WIDTH-1:0] rdData,
	input wire logic rdReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [WIDTH-1:0] outData_q, outData_d;
	logic outValid_q, outValid_d;
	logic doWrite, doRead, memEmpty;

	// ====================================================================
	// Pointer logic
	// ====================================================================
	// Full and empty from pointers with wrap bit
	assign wrReady = !((wrPtr_q[AW] != rdPtr_q[AW]) &&
		(wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
	assign memEmpty = (wrPtr_q == rdPtr_q);
	assign doWrite = ce && wrValid && wrReady && !flush;
	// Output register refills whenever it is free or drained
	assign doRead = ce && !memEmpty && (!outValid_q || rdReady) && !flush;

	// Next pointer and output values
	always_comb begin
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		outData_d = outData_q;
		outValid_d = outValid_q;
		if (ce) begin
			if (flush) begin
				// Flush drops everything held
				wrPtr_d = '0;
				rdPtr_d = '0;
				outValid_d = 1'b0;
			end else begin
				if (doWrite)
					wrPtr_d = wrPtr_q + 1'b1;
				if (doRead) begin
					rdPtr_d = rdPtr_q + 1'b1;
					outData_d = mem[rdPtr_q[AW-1:0]];
					outValid_d = 1'b1;
				end else if (rdReady) begin
					outValid_d = 1'b0;
				end
			end
		end
	end

	// Register pointers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			outData_q <= '0;
			outValid_q <= 1'b0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			outData_q <= outData_d;
			outValid_q <= outValid_d;
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge clk) begin
		if (doWrite)
			mem[wrPtr_q[AW-1:0]] <= wrData;
	end

	assign rdValid = outValid_q;
	assign rdData = outData_q;
endmodule
`default_nettype wire

//--- hw/block_transfer_flow_control.sv
// Multi-stream transfer flow controller with AXI4-Lite registers.
// Assumes processing side and host side run on clk; capture inputs are
// single-cycle pulses from logic on the same clock.
//
// Contract
// [R1] Each block stays queued from arrival until fully transmitted.
// [R2] Each stream is always in stopped, stopping, streaming or paused.
// [R3] Incoming blocks are accepted into the queue in every state.
// [R4] Streaming state sends queued words whenever data is available.
// [R5] Stopping completes the current block, then enters stopped.
// [R6] Paused suspends output at once, even mid-block.
// [R7] Stream selector targets one stream or all streams together.
// [R8] Origin selector targets one source or all sources together.
// [R9] Read-only unique tag returned for the selected source.
// [R10] Basic method disables flow control and ignores all commands.
// [R11] Auto method: capture begin starts, capture cancel flushes, no halt.
// [R12] Auto method forces run style to continuous, read only.
// [R13] Auto method leaves suspend and continue to software.
// [R14] Manual method: software commands drive the streaming state.
// [R15] Reset default is basic method, flow control disabled.
// [R16] External triggers may start and halt transfers besides commands.
// [R17] Flush stops at once and drops queued data; next block still queued.
// [R18] Bounded run ends after programmed block count or on halt.
// [R19] Continue resumes a paused stream from the suspension point.
// [R20] Begin from stopped streams; halt from streaming stops; others ignored.
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctrl_regs.svh"
module block_transfer_flow_control
	import flow_ctrl_pkg::*;
#(
	parameter int STREAMS = 2,
	parameter int DATA_W = 32,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Acquisition events
	input wire logic capture_begin,
	input wire logic capture_cancel,
	// External trigger pins
	input wire logic [STREAMS-1:0] trigBegin,
	input wire logic [STREAMS-1:0] trigHalt,
	// Processing side, per stream
	input wire logic [STREAMS-1:0] inValid,
	input wire logic [STREAMS*DATA_W-1:0] inData,
	input wire logic [STREAMS-1:0] inLast,
	output logic [STREAMS-1:0] inReady,
	// Host side, per stream
	output logic [STREAMS-1:0] outValid,
	output logic [STREAMS*DATA_W-1:0] outData,
	output logic [STREAMS-1:0] outLast,
	input wire logic [STREAMS-1:0] outReady
);
	// ====================================================================
	// Helpers
	// ====================================================================
	// Selector hit: exact index or the all value
	function automatic logic selHit(input logic [7:0] sel, input int idx);
		selHit = (sel == `SEL_ALL_VALUE) || (sel == 8'(idx));
	endfunction

	// Register write merge under byte strobes
	function automatic logic [31:0] strobeMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			strobeMerge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
	endfunction

	// ====================================================================
	// AXI4-Lite slave
	// ====================================================================
	logic [31:0] select_q, select_d, blocks_q, blocks_d;
	logic [31:0] mode_q [STREAMS];
	logic [31:0] mode_d [STREAMS];
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic awHave_q, awHave_d, wHave_q, wHave_d, bValid_q, bValid_d;
	logic arReady_q, arReady_d, rValid_q, rValid_d;
	logic [31:0] rData_q, rData_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic wrFire, cmdWrite;
	logic [4:0] cmdBits;
	logic [7:0] streamSel, originSel;
	logic [3:0] stateOf [STREAMS];

	assign streamSel = select_q[`SEL_STREAM_LSB +: 8];
	assign originSel = select_q[`SEL_ORIGIN_LSB +: 8];
	// Write fires once address and data are both held, response free
	assign wrFire = ce && awHave_q && wHave_q && !bValid_q;
	assign cmdWrite = wrFire && (awAddr_q == `REG_COMMAND) && wStrb_q[0];
	assign cmdBits = wData_q[4:0];

	// Next values of the bus slave and configuration
	always_comb begin
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		awHave_d = awHave_q;
		wHave_d = wHave_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		arReady_d = arReady_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		select_d = select_q;
		blocks_d = blocks_q;
		for (int s = 0; s < STREAMS; s++)
			mode_d[s] = mode_q[s];
		if (ce) begin
			if (s_axi_awvalid && !awHave_q) begin
				awAddr_d = s_axi_awaddr;
				awHave_d = 1'b1;
			end
			if (s_axi_wvalid && !wHave_q) begin
				wData_d = s_axi_wdata;
				wStrb_d = s_axi_wstrb;
				wHave_d = 1'b1;
			end
			if (bValid_q && s_axi_bready)
				bValid_d = 1'b0;
			if (wrFire) begin
				awHave_d = 1'b0;
				wHave_d = 1'b0;
				bValid_d = 1'b1;
				bResp_d = 2'h0;
				unique case (awAddr_q)
					`REG_SELECT: select_d = strobeMerge(select_q, wData_q, wStrb_q);
					`REG_BLOCKS: blocks_d = strobeMerge(blocks_q, wData_q, wStrb_q);
					`REG_MODE: begin
						for (int s = 0; s < STREAMS; s++)
							if (selHit(streamSel, s)) // [R7]
								mode_d[s] = strobeMerge(mode_q[s], wData_q, wStrb_q);
					end
					`REG_COMMAND: ;
					default: bResp_d = 2'h2;
				endcase
			end
			if (rValid_q && s_axi_rready)
				rValid_d = 1'b0;
			// Data only after the address handshake, as the bus requires
			arReady_d = s_axi_arvalid && !rValid_q && !arReady_q;
			if (arReady_q && s_axi_arvalid) begin
				rValid_d = 1'b1;
				rResp_d = 2'h0;
				rData_d = 32'h0;
				unique case (s_axi_araddr)
					`REG_SELECT: rData_d = select_q;
					`REG_BLOCKS: rData_d = blocks_q;
					`REG_MODE: begin
						for (int s = 0; s < STREAMS; s++)
							if (streamSel == 8'(s)) begin
								rData_d = mode_q[s] & 32'h0000_0013;
								if (mode_q[s][1:0] == 2'(METHOD_AUTO))
									rData_d[`MODE_STYLE_BIT] = 1'b0; // [R12]
							end
					end
					`REG_STATUS: begin
						for (int s = 0; s < STREAMS; s++)
							if (streamSel == 8'(s))
								rData_d[3:0] = stateOf[s];
					end
					`REG_ORIGIN_TAG: begin
						if (originSel != `SEL_ALL_VALUE)
							rData_d = `ORIGIN_TAG_BASE + {24'h0, originSel}; // [R9]
					end
					`REG_COMMAND: ;
					default: rResp_d = 2'h2;
				endcase
			end
		end
	end

	// Register the bus slave and configuration
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awAddr_q <= 8'h00;
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= 2'h0;
			arReady_q <= 1'b0;
			rValid_q <= 1'b0;
			rData_q <= 32'h0;
			rResp_q <= 2'h0;
			select_q <= `RST_SELECT;
			blocks_q <= `RST_BLOCKS;
			for (int s = 0; s < STREAMS; s++)
				mode_q[s] <= `RST_MODE; // [R15]
		end else begin
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			awHave_q <= awHave_d;
			wHave_q <= wHave_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			arReady_q <= arReady_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
			select_q <= select_d;
			blocks_q <= blocks_d;
			for (int s = 0; s < STREAMS; s++)
				mode_q[s] <= mode_d[s];
		end
	end

	assign s_axi_awready = !awHave_q;
	assign s_axi_wready = !wHave_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	// ====================================================================
	// Per-stream queue and streaming control
	// ====================================================================
	logic [STREAMS-1:0] trigBeginM_q, trigBeginS_q, trigHaltM_q, trigHaltS_q;

	// Pin triggers pass a two-stage synchroniser
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trigBeginM_q <= '0;
			trigBeginS_q <= '0;
			trigHaltM_q <= '0;
			trigHaltS_q <= '0;
		end else if (ce) begin
			trigBeginM_q <= trigBegin;
			trigBeginS_q <= trigBeginM_q;
			trigHaltM_q <= trigHalt;
			trigHaltS_q <= trigHaltM_q;
		end
	end

	for (genvar g = 0; g < STREAMS; g++) begin : gStream
		stream_state_t state_q, state_d;
		logic midBlock_q, midBlock_d, trigPrev_q, trigHaltPrev_q;
		logic [31:0] sent_q, sent_d;
		logic qValid, qReady, qLast, flush, beginEv, haltEv;
		logic suspendEv, continueEv, bounded, sendOk, wordGo;
		logic [DATA_W:0] qData;
		logic [1:0] method;
		logic hit, isBasic, isAuto, isManual;

		assign method = mode_q[g][`MODE_METHOD_LSB +: 2];
		assign isBasic = (method != 2'(METHOD_AUTO)) &&
			(method != 2'(METHOD_MANUAL)); // [R10] [R15]
		assign isAuto = (method == 2'(METHOD_AUTO));
		assign isManual = (method == 2'(METHOD_MANUAL));
		assign hit = cmdWrite && selHit(streamSel, g); // [R7]
		// Capture events reach streams of the selected origins
		assign beginEv = (isManual && hit && cmdBits[`CMD_BEGIN_BIT]) || // [R14]
			(isAuto && capture_begin && selHit(originSel, g)) || // [R8] [R11]
			(!isBasic && trigBeginS_q[g] && !trigPrev_q); // [R16]
		assign haltEv = (isManual && hit && cmdBits[`CMD_HALT_BIT]) ||
			(!isBasic && trigHaltS_q[g] && !trigHaltPrev_q); // [R16]
		assign flush = ce && ((isManual && hit && cmdBits[`CMD_FLUSH_BIT]) ||
			(isAuto && capture_cancel && selHit(originSel, g))); // [R11] [R17]
		assign suspendEv = !isBasic && hit && cmdBits[`CMD_SUSPEND_BIT]; // [R13]
		assign continueEv = !isBasic && hit && cmdBits[`CMD_CONTINUE_BIT];
		assign bounded = isManual && mode_q[g][`MODE_STYLE_BIT]; // [R12]

		// Queue takes new words whenever it has room and no flush is on, regardless of state
		block_queue #(.WIDTH(DATA_W + 1), .DEPTH(DEPTH)) uQueue (
			.clk(clk),
			.arst_n(arst_n),
			.ce(ce),
			.flush(flush),
			.wrValid(inValid[g]),
			.wrData({inLast[g], inData[g*DATA_W +: DATA_W]}), // [R3]
			.wrReady(inReady[g]),
			.rdValid(qValid),
			.rdData(qData),
			.rdReady(qReady)
		);
		assign qLast = qData[DATA_W];
		// Basic mode streams freely; paused holds the word in place
		assign sendOk = isBasic || (state_q == ST_STREAMING) ||
			(state_q == ST_STOPPING && midBlock_q); // [R4] [R5] [R6]
		// Word leaves the queue only when host takes it or a flush drops it
		assign qReady = sendOk && outReady[g] && !flush; // [R1]
		assign wordGo = ce && qValid && qReady;

		// Next streaming state
		always_comb begin
			state_d = state_q;
			midBlock_d = midBlock_q;
			sent_d = sent_q;
			if (ce) begin
				if (wordGo)
					midBlock_d = !qLast;
				if (wordGo && qLast)
					sent_d = sent_q + 32'h1;
				unique case (state_q) // [R2]
					ST_STOPPED: if (beginEv) begin
						state_d = ST_STREAMING; // [R20]
						sent_d = 32'h0;
					end
					ST_STREAMING: begin
						if (suspendEv)
							state_d = ST_PAUSED; // [R6]
						else if (haltEv || (bounded && wordGo && qLast &&
							sent_q + 32'h1 >= blocks_q))
							state_d = ST_STOPPING; // [R18] [R20]
					end
					ST_STOPPING: if (!midBlock_d)
						state_d = ST_STOPPED; // [R5]
					ST_PAUSED: if (continueEv)
						state_d = ST_STREAMING; // [R19]
				endcase
				if (flush || isBasic) begin
					state_d = ST_STOPPED; // [R17]
					midBlock_d = 1'b0;
				end
			end
		end

		// Register streaming state
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				state_q <= ST_STOPPED;
				midBlock_q <= 1'b0;
				sent_q <= 32'h0;
				trigPrev_q <= 1'b0;
				trigHaltPrev_q <= 1'b0;
			end else begin
				state_q <= state_d;
				midBlock_q <= midBlock_d;
				sent_q <= sent_d;
				if (ce) begin
					trigPrev_q <= trigBeginS_q[g];
					trigHaltPrev_q <= trigHaltS_q[g];
				end
			end
		end

		assign stateOf[g] = state_q;
		assign outValid[g] = qValid && sendOk;
		assign outData[g*DATA_W +: DATA_W] = qData[DATA_W-1:0];
		assign outLast[g] = qLast;
	end
endmodule
`default_nettype wire

//--- bench/flow_ctrl_props.sv
// Checker for the flow controller's top-level ports.
// Assumes one clock domain, with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module flow_ctrl_props #(
	parameter int STREAMS = 2,
	parameter int DATA_W = 32
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Host side
	input wire logic [STREAMS-1:0] outValid,
	input wire logic [STREAMS*DATA_W-1:0] outData,
	input wire logic [STREAMS-1:0] outReady
);
	// ==========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	read_answer_a: assert property (
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered after address taken");
	arready_pulse_a: assert property (
		ce && s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	write_answer_a: assert property (
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	held_fire_a: assert property (
		ce && !s_axi_awready && !s_axi_wready && !s_axi_bvalid
		|=> s_axi_bvalid)
		else $error("held write not answered");
	out_stable_a: assert property (
		outValid[0] && !outReady[0]
		|=> !outValid[0] || $stable(outData[DATA_W-1:0]))
		else $error("stream word changed while waiting");
	reset_quiet_a: assert property (
		$rose(arst_n) |-> !s_axi_bvalid && !s_axi_rvalid && outValid == '0)
		else $error("activity right after reset");

	// Main scenarios reached
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (outValid[0] && !outReady[0]);
endmodule
bind block_transfer_flow_control flow_ctrl_props #(
	.STREAMS(STREAMS),
	.DATA_W(DATA_W)
) props (.clk, .arst_n, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.outValid, .outData, .outReady);
`default_nettype wire

//--- bench/host_sink.sv
// Host model for one stream: collects words, may stall.
// Assumes valid/ready words on the same clock as the design.
`timescale 1ns/1ps
`default_nettype none
module host_sink #(
	parameter int DATA_W = 32
) (
	// Clock and stall controls
	input wire logic clk,
	input wire logic hold,
	input wire logic slow,
	// Stream
	input wire logic outValid,
	input wire logic [DATA_W-1:0] outData,
	output logic outReady
);
	logic [DATA_W-1:0] got[$];
	int seed = 32'h878E;

	initial outReady = 1'h0;
	// Random back-pressure so gating is seen under stalls
	always @(posedge clk) begin
		if (outValid && outReady)
			got.push_back(outData);
		outReady <= !hold && (!slow || $random(seed) % 2 != 0);
	end
endmodule
`default_nettype wire

//--- bench/tb_block_transfer_flow_control.sv
// Self-checking bench: registers over AXI4-Lite, stream gating by state.
// Assumes the package, the register header and the design are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctrl_regs.svh"
module tb_block_transfer_flow_control import flow_ctrl_pkg::*;;
	logic clk, arst_n, ce, captureBegin, captureCancel, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, inValid, inLast, inReady;
	logic [1:0] outValid, outLast, outReady, hold, trig;
	logic [63:0] inData, outData;
	logic [31:0] expQ[$];
	int errors, totalChecks, seed, n;

	// 200 MHz clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	block_transfer_flow_control #(.STREAMS(2)) uut (.clk, .arst_n, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .capture_begin(captureBegin),
		.capture_cancel(captureCancel), .trigBegin(trig), .trigHalt(trig),
		.inValid, .inData, .inLast, .inReady, .outValid, .outData,
		.outLast, .outReady);
	host_sink sink0 (.clk, .hold(hold[0]), .slow, .outValid(outValid[0]),
		.outData(outData[31:0]), .outReady(outReady[0]));
	host_sink sink1 (.clk, .hold(hold[1]), .slow, .outValid(outValid[1]),
		.outData(outData[63:32]), .outReady(outReady[1]));

	// ==========
	// Helpers
	task automatic stopTest();
		if (errors == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic hang();
		errors++;
		$display("mismatch at %0t: wait ran out", $time);
		stopTest();
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Each channel released at the edge that takes it; sampled mid-cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic awT, wT, bT;
		@(posedge clk);
		bT = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int i = 0; i < 50 && !bT; i++) begin
			@(negedge clk);
			awT = s_axi_awready;
			wT = s_axi_wready;
			bT = s_axi_bvalid;
			@(posedge clk);
			if (awT) s_axi_awvalid <= 1'h0;
			if (wT) s_axi_wvalid <= 1'h0;
			if (bT) s_axi_bready <= 1'h0;
		end
		if (!bT) hang();
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic arT, rT;
		@(posedge clk);
		rT = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int i = 0; i < 50 && !rT; i++) begin
			@(negedge clk);
			arT = s_axi_arready;
			rT = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (arT) s_axi_arvalid <= 1'h0;
			if (rT) s_axi_rready <= 1'h0;
		end
		if (!rT) hang();
		check(rd, e);
	endtask

	// One block of random words; kept ones enter the delivery model
	task automatic push(input int s, input int len, input bit keep);
		logic [31:0] w;
		int k;
		@(posedge clk);
		for (int i = 0; i < len; i++) begin
			w = $random(seed);
			inValid[s] <= 1'h1;
			inData[s*32 +: 32] <= w;
			inLast[s] <= (i == len - 1);
			k = 0;
			do begin
				@(negedge clk);
				k++;
			end while (!inReady[s] && k < 200);
			if (k >= 200) hang();
			@(posedge clk);
			if (keep) expQ.push_back(w);
		end
		inValid[s] <= 1'h0;
	endtask

	task automatic drain();
		for (int k = 0; k < 400 && sink0.got.size() < expQ.size(); k++)
			@(posedge clk);
		tick(5);
		check(32'(sink0.got.size()), 32'(expQ.size()));
		foreach (expQ[i])
			if (i < sink0.got.size()) check(sink0.got[i], expQ[i]);
	endtask

	task automatic waitMore(input int base);
		for (int k = 0; k < 200 && sink0.got.size() <= base; k++)
			@(negedge clk);
		if (sink0.got.size() <= base) hang();
	endtask

	task automatic pulse(input bit cancel);
		@(posedge clk);
		captureBegin <= !cancel;
		captureCancel <= cancel;
		@(posedge clk);
		captureBegin <= 1'h0;
		captureCancel <= 1'h0;
	endtask

	// ==========
	// Main sequence
	initial begin
		{arst_n, captureBegin, captureCancel, slow, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, inData} = '0;
		{inValid, inLast, hold, trig} = '0;
		s_axi_wstrb = 4'hF;
		ce = 1'h1;
		seed = 32'h878E;
		tick(2);
		arst_n <= 1'h1;
		// Reset values and an unmapped word
		rc(`REG_MODE, `RST_MODE);
		rc(`REG_BLOCKS, `RST_BLOCKS);
		rc(`REG_STATUS, 32'(ST_STOPPED));
		rc(`REG_ORIGIN_TAG, `ORIGIN_TAG_BASE);
		rc(8'h18, 32'h0);
		check({30'h0, rsp}, 32'h2);
		// Basic: commands ignored, words flow under stalls
		slow = 1'h1;
		wr(`REG_COMMAND, 32'h1);
		rc(`REG_STATUS, 32'(ST_STOPPED));
		push(0, 4, 1);
		drain();
		// Manual: stopped holds blocks until begin
		wr(`REG_MODE, 32'h2);
		push(0, 3, 1);
		tick(20);
		check(32'(sink0.got.size()), 32'h4);
		wr(`REG_COMMAND, 32'h1);
		rc(`REG_STATUS, 32'(ST_STREAMING));
		drain();
		// Suspend mid-block, then continue from the same word
		slow = 1'h0;
		hold[0] <= 1'h1;
		n = sink0.got.size();
		push(0, 12, 1);
		hold[0] <= 1'h0;
		waitMore(n);
		wr(`REG_COMMAND, 32'h8);
		@(negedge clk);
		n = sink0.got.size();
		tick(10);
		@(negedge clk);
		check(32'(sink0.got.size()), 32'(n));
		rc(`REG_STATUS, 32'(ST_PAUSED));
		wr(`REG_COMMAND, 32'h10);
		drain();
		// Halt mid-block completes the block
		hold[0] <= 1'h1;
		n = sink0.got.size();
		push(0, 10, 1);
		hold[0] <= 1'h0;
		waitMore(n);
		wr(`REG_COMMAND, 32'h2);
		drain();
		rc(`REG_STATUS, 32'(ST_STOPPED));
		// Flush drops queued words; the next block still goes out
		hold[0] <= 1'h1;
		wr(`REG_COMMAND, 32'h1);
		push(0, 2, 0);
		wr(`REG_COMMAND, 32'h4);
		hold[0] <= 1'h0;
		rc(`REG_STATUS, 32'(ST_STOPPED));
		wr(`REG_COMMAND, 32'h1);
		push(0, 3, 1);
		drain();
		// Count runs from begin: the block just sent is the first of three
		wr(`REG_BLOCKS, 32'h3);
		wr(`REG_MODE, 32'h12);
		push(0, 2, 1);
		push(0, 2, 1);
		drain();
		push(0, 2, 1);
		tick(20);
		check(32'(sink0.got.size()), 32'(expQ.size() - 2));
		rc(`REG_STATUS, 32'(ST_STOPPED));
		// Auto: capture events drive the state, halt ignored
		wr(`REG_MODE, 32'h11);
		rc(`REG_MODE, 32'h1);
		pulse(0);
		rc(`REG_STATUS, 32'(ST_STREAMING));
		drain();
		wr(`REG_COMMAND, 32'h2);
		rc(`REG_STATUS, 32'(ST_STREAMING));
		wr(`REG_COMMAND, 32'h8);
		rc(`REG_STATUS, 32'(ST_PAUSED));
		wr(`REG_COMMAND, 32'h10);
		rc(`REG_STATUS, 32'(ST_STREAMING));
		pulse(1);
		rc(`REG_STATUS, 32'(ST_STOPPED));
		// All-streams and origin selection
		wr(`REG_SELECT, 32'h0000_00FF);
		wr(`REG_MODE, 32'h2);
		wr(`REG_SELECT, 32'h0000_0101);
		rc(`REG_MODE, 32'h2);
		rc(`REG_ORIGIN_TAG, `ORIGIN_TAG_BASE + 32'h1);
		push(1, 2, 0);
		wr(`REG_SELECT, 32'h0000_00FF);
		wr(`REG_COMMAND, 32'h1);
		wr(`REG_SELECT, 32'h0000_0001);
		rc(`REG_STATUS, 32'(ST_STREAMING));
		tick(20);
		check(32'(sink1.got.size()), 32'h2);
		// All origins cancel at once; a pin edge then restarts stream 1
		wr(`REG_SELECT, 32'h0000_FFFF);
		wr(`REG_MODE, 32'h1);
		pulse(1);
		wr(`REG_SELECT, 32'h0000_0001);
		rc(`REG_STATUS, 32'(ST_STOPPED));
		trig <= 2'h3;
		tick(6);
		trig <= 2'h0;
		rc(`REG_STATUS, 32'(ST_STREAMING));
		stopTest();
	end
endmodule
`default_nettype wire
